/* ccms_defs.svh */
`ifndef CCMS_DEFS_SVH
`define CCMS_DEFS_SVH

// APB register byte addresses
`define CCMS_ADDR_LATCH 12'h000
`define CCMS_ADDR_CTRL 12'h004
`define CCMS_ADDR_RELOAD 12'h008
`define CCMS_ADDR_STAT 12'h00C

// Reset values
`define CCMS_LATCH_RST 8'hFF
`define CCMS_CTRL_RST 16'h0000

// Clock source select field position inside the latch
`define CCMS_SEL_HI 7
`define CCMS_SEL_LO 5

// Upper half of the reset control register
`define CCMS_CTRL_UP_HI 15
`define CCMS_CTRL_UP_LO 8

// Reload command bit in the reload register
`define CCMS_RELOAD_BIT 0

// One-hot register select positions
`define CCMS_HIT_LATCH 0
`define CCMS_HIT_CTRL 1
`define CCMS_HIT_RELOAD 2
`define CCMS_HIT_STAT 3

// Status word field positions
`define CCMS_ST_OSC 0
`define CCMS_ST_MODE_HI 2
`define CCMS_ST_MODE_LO 1
`define CCMS_ST_CAP 3
`define CCMS_ST_CPU 4
`define CCMS_ST_PLL 5
`define CCMS_ST_PER_HI 31
`define CCMS_ST_PER_LO 16

// Clock source select codes
`define CCMS_CODE_X4 3'h7
`define CCMS_CODE_X3 3'h6
`define CCMS_CODE_X2 3'h5
`define CCMS_CODE_X5 3'h4
`define CCMS_CODE_DIRECT 3'h3
`define CCMS_CODE_X1P5 3'h2
`define CCMS_CODE_PRE 3'h1
`define CCMS_CODE_X2P5 3'h0

// PLL factor as twice F (TCLs per oscillator period)
`define CCMS_TWICE_X4 4'h8
`define CCMS_TWICE_X3 4'h6
`define CCMS_TWICE_X2 4'h4
`define CCMS_TWICE_X5 4'hA
`define CCMS_TWICE_X1 4'h2
`define CCMS_TWICE_X1P5 4'h3
`define CCMS_TWICE_X2P5 4'h5

// Cycles to wait after reset release before sampling the strap pins
`define CCMS_CAP_WAIT 3'h4

// Transition weight in half-units of F
`define CCMS_TRANS_STEP 4'h2

`endif

/* ccms_pkg.sv */
package ccms_pkg;

   typedef enum logic [1:0] {
      CCMS_MODE_PLL,
      CCMS_MODE_PRE,
      CCMS_MODE_DIRECT
   } ccms_mode_type;

   typedef struct packed {
      ccms_mode_type mode;
      logic [3:0] twice_f;
   } ccms_cfg_type;

endpackage

/* ccms_sync.sv */
`timescale 1ns/10ps
module ccms_sync
   import ccms_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] out_ff;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // A bit moves only when the second and third stages agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               out_ff[i] <= 1'b0;
            end else if (s2_ff[i] == s3_ff[i]) begin
               out_ff[i] <= s3_ff[i];
            end
         end
      end
   endgenerate

   assign dout = out_ff;

endmodule // ccms_sync

/* ccms_top.sv */
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "ccms_defs.svh"

module ccms_top
   import ccms_pkg::*;
#(
   parameter int PW = 16,
   parameter logic [PW-1:0] PERIOD_INIT = 16'h0040
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic osc_in,
   input wire logic [7:0] port_zero_upper_byte,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cpu_clk,
   output logic clock_half_period,
   output logic pll_en
);

   function automatic ccms_cfg_type decode_sel(input logic [2:0] code);
      ccms_cfg_type c;
      c.mode = CCMS_MODE_PLL;
      c.twice_f = `CCMS_TWICE_X4;
      case (code)
         `CCMS_CODE_X4: c.twice_f = `CCMS_TWICE_X4;
         `CCMS_CODE_X3: c.twice_f = `CCMS_TWICE_X3;
         `CCMS_CODE_X2: c.twice_f = `CCMS_TWICE_X2;
         `CCMS_CODE_X5: c.twice_f = `CCMS_TWICE_X5;
         `CCMS_CODE_X1P5: c.twice_f = `CCMS_TWICE_X1P5;
         `CCMS_CODE_X2P5: c.twice_f = `CCMS_TWICE_X2P5;
         `CCMS_CODE_DIRECT: begin
            c.mode = CCMS_MODE_DIRECT;
            c.twice_f = `CCMS_TWICE_X1;
         end
         `CCMS_CODE_PRE: begin
            c.mode = CCMS_MODE_PRE;
            c.twice_f = `CCMS_TWICE_X1;
         end
         default: c.twice_f = `CCMS_TWICE_X4;
      endcase
      return c;
   endfunction

   // One-hot register select, shared by the read mux and both write paths
   function automatic logic [3:0] reg_hit(input logic [11:0] addr);
      logic [3:0] h;
      h = 4'h0;
      if (addr == `CCMS_ADDR_LATCH) begin
         h[`CCMS_HIT_LATCH] = 1'b1;
      end else if (addr == `CCMS_ADDR_CTRL) begin
         h[`CCMS_HIT_CTRL] = 1'b1;
      end else if (addr == `CCMS_ADDR_RELOAD) begin
         h[`CCMS_HIT_RELOAD] = 1'b1;
      end else if (addr == `CCMS_ADDR_STAT) begin
         h[`CCMS_HIT_STAT] = 1'b1;
      end
      return h;
   endfunction

   localparam int PER_W = `CCMS_ST_PER_HI - `CCMS_ST_PER_LO + 1;

   logic [8:0] sync_out;
   logic osc_lvl;
   logic [7:0] pins_lvl;
   logic osc_prev_ff;
   logic osc_rise;
   logic osc_edge;
   logic [7:0] latch_ff;
   logic [15:0] ctrl_ff;
   logic [2:0] cap_cnt_ff;
   logic cap_done_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic [31:0] nxt_prdata;
   logic nxt_pslverr;
   logic wr_en;
   logic reload_req;
   logic [3:0] hit;
   logic [31:0] stat_word;
   logic cap_fire;
   ccms_cfg_type cfg;
   logic [PW-1:0] meas_cnt_ff;
   logic [PW-1:0] meas_ff;
   logic [PW-1:0] per_used_ff;
   logic [PW-1:0] acc_ff;
   logic [PW-1:0] nxt_acc;
   logic [PW:0] acc_sum;
   logic dda_tick;
   logic [3:0] trans_ff;
   logic [4:0] trans_sum;
   logic resync;
   logic cpu_clk_ff;
   logic nxt_cpu_clk;
   logic tcl_ff;
   logic pll_en_ff;

   // The oscillator and strap pins come from outside this clock
   ccms_sync #(
      .WIDTH(9)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .din({osc_in, port_zero_upper_byte}),
      .dout(sync_out)
   );

   assign osc_lvl = sync_out[8];
   assign pins_lvl = sync_out[7:0];

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         osc_prev_ff <= 1'b0;
      end else begin
         osc_prev_ff <= osc_lvl;
      end
   end

   assign osc_rise = osc_lvl & ~osc_prev_ff;
   assign osc_edge = osc_lvl ^ osc_prev_ff;

   // APB slave, zero wait states; read data is staged in the setup cycle
   assign hit = reg_hit(paddr);
   assign wr_en = psel & penable & pwrite;
   assign reload_req = wr_en && hit[`CCMS_HIT_RELOAD] && pwdata[`CCMS_RELOAD_BIT];

   // Status fields placed by name so the layout is kept in one spot
   always_comb begin
      stat_word = '0;
      stat_word[`CCMS_ST_OSC] = osc_lvl;
      stat_word[`CCMS_ST_MODE_HI:`CCMS_ST_MODE_LO] = cfg.mode;
      stat_word[`CCMS_ST_CAP] = cap_done_ff;
      stat_word[`CCMS_ST_CPU] = cpu_clk_ff;
      stat_word[`CCMS_ST_PLL] = pll_en_ff;
      stat_word[`CCMS_ST_PER_HI:`CCMS_ST_PER_LO] = PER_W'(meas_ff);
   end

   always_comb begin
      nxt_prdata = '0;
      nxt_pslverr = 1'b0;
      if (hit[`CCMS_HIT_LATCH]) begin
         nxt_prdata = {24'h00_0000, latch_ff};
      end else if (hit[`CCMS_HIT_CTRL]) begin
         nxt_prdata = {16'h0000, ctrl_ff};
      end else if (hit[`CCMS_HIT_RELOAD]) begin
         nxt_prdata = '0;
      end else if (hit[`CCMS_HIT_STAT]) begin
         nxt_prdata = stat_word;
      end else begin
         nxt_pslverr = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prdata_ff <= '0;
      end else if (psel && !penable) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      end
   end

   // Error flag stands with the read data until the next setup cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pslverr_ff <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;
   assign pready = 1'b1;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= `CCMS_CTRL_RST;
      end else if (wr_en && hit[`CCMS_HIT_CTRL]) begin
         ctrl_ff <= pwdata[15:0];
      end
   end

   // Strap capture waits until the synchroniser has filled after release
   assign cap_fire = !cap_done_ff && (cap_cnt_ff == `CCMS_CAP_WAIT);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cap_cnt_ff <= '0;
      end else if (!cap_done_ff) begin
         cap_cnt_ff <= cap_cnt_ff + 3'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cap_done_ff <= 1'b0;
      end else if (cap_fire) begin
         cap_done_ff <= 1'b1;
      end
   end

   // Latch moves only on these two events; a reload in the capture cycle loses
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         latch_ff <= `CCMS_LATCH_RST;
      end else if (cap_fire) begin
         latch_ff <= pins_lvl;
      end else if (reload_req) begin
         latch_ff <= ctrl_ff[`CCMS_CTRL_UP_HI:`CCMS_CTRL_UP_LO];
      end
   end

   assign cfg = decode_sel(latch_ff[`CCMS_SEL_HI:`CCMS_SEL_LO]);

   // Oscillator period in system cycles, measured rise to rise
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meas_cnt_ff <= '0;
      end else if (osc_rise) begin
         meas_cnt_ff <= {{(PW-1){1'b0}}, 1'b1};
      end else if (meas_cnt_ff != '1) begin
         meas_cnt_ff <= meas_cnt_ff + {{(PW-1){1'b0}}, 1'b1};
      end
   end

   // A stopped oscillator leaves the last good period in place
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meas_ff <= PERIOD_INIT;
      end else if (osc_rise) begin
         meas_ff <= meas_cnt_ff;
      end
   end

   // Resync every F transitions, counted in half-units so 1.5 and 2.5 work
   assign trans_sum = {1'b0, trans_ff} + {1'b0, `CCMS_TRANS_STEP};
   assign resync = osc_edge && (trans_sum >= {1'b0, cfg.twice_f});

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trans_ff <= '0;
      end else if (osc_edge) begin
         trans_ff <= resync ? 4'(trans_sum - {1'b0, cfg.twice_f}) : trans_sum[3:0];
      end
   end

   // One step per resync so an oscillator period change never makes the CPU clock frequency jump
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         per_used_ff <= PERIOD_INIT;
      end else if (resync) begin
         if (per_used_ff < meas_ff) begin
            per_used_ff <= per_used_ff + {{(PW-1){1'b0}}, 1'b1};
         end else if (per_used_ff > meas_ff) begin
            per_used_ff <= per_used_ff - {{(PW-1){1'b0}}, 1'b1};
         end
      end
   end

   // Rate accumulator: 2F edges per oscillator period, spread evenly
   assign acc_sum = {1'b0, acc_ff} + {{(PW-3){1'b0}}, cfg.twice_f};
   assign dda_tick = acc_sum >= {1'b0, per_used_ff};

   always_comb begin
      nxt_acc = acc_sum[PW-1:0];
      if (dda_tick) begin
         nxt_acc = PW'(acc_sum - {1'b0, per_used_ff});
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         acc_ff <= '0;
      end else if (cfg.mode != CCMS_MODE_PLL) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   always_comb begin
      nxt_cpu_clk = cpu_clk_ff;
      case (cfg.mode)
         CCMS_MODE_DIRECT: nxt_cpu_clk = osc_lvl;
         CCMS_MODE_PRE: begin
            if (osc_rise) begin
               nxt_cpu_clk = ~cpu_clk_ff;
            end
         end
         default: begin
            if (dda_tick) begin
               nxt_cpu_clk = ~cpu_clk_ff;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cpu_clk_ff <= 1'b0;
      end else begin
         cpu_clk_ff <= nxt_cpu_clk;
      end
   end

   // Each CPU clock edge is one timing unit, flagged in the same cycle as the edge
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tcl_ff <= 1'b0;
      end else begin
         tcl_ff <= nxt_cpu_clk ^ cpu_clk_ff;
      end
   end

   // Follows the latch one cycle late; the analog loop itself is not modelled
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pll_en_ff <= 1'b0;
      end else begin
         pll_en_ff <= (cfg.mode == CCMS_MODE_PLL);
      end
   end

   assign cpu_clk = cpu_clk_ff;
   assign clock_half_period = tcl_ff;
   assign pll_en = pll_en_ff;

endmodule // ccms_top

/* ccms_osc_model.sv */
`timescale 1ns/10ps
module ccms_osc_model #(
   parameter int HI_NS = 56,
   parameter int LO_NS = 104,
   parameter logic [7:0] STRAP = 8'h3C
) (
   output logic osc_in,
   output logic [7:0] port_zero_upper_byte
);
   // Straps stand still from time zero, since capture follows the reset release
   assign port_zero_upper_byte = STRAP;
   // Edges sit 2 ns after a grid point, so each is sampled at one known edge
   initial begin
      osc_in = 1'b0;
      #2;
      forever begin
         osc_in = 1'b1;
         #HI_NS;
         osc_in = 1'b0;
         #LO_NS;
      end
   end
endmodule // ccms_osc_model

/* ccms_top_checker.sv */
`timescale 1ns/10ps
`include "ccms_defs.svh"
module ccms_top_checker
   import ccms_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic osc_in,
   input wire logic [7:0] port_zero_upper_byte,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cpu_clk,
   input wire logic clock_half_period,
   input wire logic pll_en
);
   wire logic acc = psel && penable;
   wire logic rd = acc && !pwrite;
   wire logic rld = acc && pwrite && paddr == `CCMS_ADDR_RELOAD;
   logic [3:0] cyc_ff;
   // Saturating count hides the strap capture that follows every reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) cyc_ff <= 4'h0;
      else if (cyc_ff != 4'hF) cyc_ff <= cyc_ff + 4'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_edge_pulse: assert property ($changed(cpu_clk) |-> clock_half_period)
      else $error("no pulse after cpu clock edge");
   a_pulse_cause: assert property (clock_half_period |-> $changed(cpu_clk))
      else $error("pulse without cpu clock edge");
   a_pll_code: assert property (rd && paddr == `CCMS_ADDR_LATCH |-> pll_en == !(!prdata[7] && prdata[5]))
      else $error("pll enable disagrees with code");
   a_latch_width: assert property (rd && paddr == `CCMS_ADDR_LATCH |-> prdata[31:8] == 24'h00_0000)
      else $error("latch upper bits not zero");
   a_ctrl_width: assert property (rd && paddr == `CCMS_ADDR_CTRL |-> prdata[31:16] == 16'h0000)
      else $error("control upper bits not zero");
   a_stat_mode: assert property (rd && paddr == `CCMS_ADDR_STAT |-> ((prdata[2:1] == 2'd0) == pll_en) && prdata[5] == pll_en)
      else $error("status mode disagrees with pll enable");
   a_pll_steady: assert property ($changed(pll_en) |-> cyc_ff < 4'hA || $past(rld) || $past(rld, 2))
      else $error("pll enable moved without reload");
   a_read_hold: assert property (acc |=> prdata == $past(prdata))
      else $error("read data moved after access");
   a_bad_addr: assert property (acc && paddr > `CCMS_ADDR_STAT |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
endmodule // ccms_top_checker

bind ccms_top ccms_top_checker u_ccms_top_checker (.*);

/* ccms_top_tb_top.sv */
`timescale 1ns/10ps
`include "ccms_defs.svh"
module ccms_top_tb_top;
   import ccms_pkg::*;
   logic clk_sys, rst_b, osc_in, psel, penable, pwrite, pready, pslverr, er;
   logic cpu_clk, clock_half_period, pll_en;
   logic [7:0] port_zero_upper_byte;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [2:0] code [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
   int tf [6] = '{8, 6, 4, 10, 3, 5};
   int n_fail = 0;
   int total_checks = 0;
   int hi, lo, c, e;
   ccms_top u_ccms_top (.*);
   ccms_osc_model #(.HI_NS(56), .LO_NS(104), .STRAP(8'h3C)) u_ccms_osc_model (.*);
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Skips the switch-over transient, then times one high and one low phase
   task automatic meas;
      hi = 0;
      lo = 0;
      repeat (40) @(posedge clk_sys);
      while (cpu_clk !== 1'b0) @(posedge clk_sys);
      while (cpu_clk !== 1'b1) @(posedge clk_sys);
      while (cpu_clk === 1'b1) begin
         @(posedge clk_sys);
         hi++;
      end
      while (cpu_clk === 1'b0) begin
         @(posedge clk_sys);
         lo++;
      end
   endtask
   task automatic test_done;
      if (n_fail == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      #480000;
      n_fail++;
      test_done();
   end
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      apb(1'b0, `CCMS_ADDR_LATCH, 32'h0000_0000);
      chk("latch reset", 32'h0000_00FF, rv);
      chk("latch err", 32'h0000_0000, er);
      apb(1'b0, `CCMS_ADDR_CTRL, 32'h0000_0000);
      chk("ctrl reset", 32'h0000_0000, rv);
      apb(1'b0, `CCMS_ADDR_LATCH, 32'h0000_0000);
      chk("latch strap", 32'h0000_003C, rv);
      apb(1'b0, `CCMS_ADDR_STAT, 32'h0000_0000);
      chk("mode prescaler", 32'h0000_0001, rv[2:1]);
      chk("pll off", 32'h0000_0000, pll_en);
      meas();
      chk("prescaler high", 32'd20, hi);
      chk("prescaler low", 32'd20, lo);
      apb(1'b1, `CCMS_ADDR_CTRL, 32'hFFFF_FFFF);
      apb(1'b1, `CCMS_ADDR_LATCH, 32'h0000_0000);
      apb(1'b0, `CCMS_ADDR_CTRL, 32'h0000_0000);
      chk("ctrl width", 32'h0000_FFFF, rv);
      apb(1'b0, `CCMS_ADDR_LATCH, 32'h0000_0000);
      chk("latch held", 32'h0000_003C, rv);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, er);
      chk("unmapped data", 32'h0000_0000, rv);
      apb(1'b1, `CCMS_ADDR_CTRL, 32'h0000_6000);
      apb(1'b1, `CCMS_ADDR_RELOAD, 32'h0000_0001);
      apb(1'b0, `CCMS_ADDR_LATCH, 32'h0000_0000);
      chk("latch reload", 32'h0000_0060, rv);
      chk("pll off direct", 32'h0000_0000, pll_en);
      meas();
      chk("direct high", 32'd7, hi);
      chk("direct low", 32'd13, lo);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `CCMS_ADDR_CTRL, {16'h0000, code[i], 13'h0000});
         apb(1'b1, `CCMS_ADDR_RELOAD, 32'h0000_0001);
         apb(1'b0, `CCMS_ADDR_STAT, 32'h0000_0000);
         chk("pll on", 32'h0000_0001, pll_en);
         repeat (3000) @(posedge clk_sys);
         c = 0;
         repeat (200) begin
            @(posedge clk_sys);
            if (clock_half_period === 1'b1) c++;
         end
         // Ten oscillator periods carry 2F half-periods each; resync may shift one or two
         e = 10 * tf[i];
         chk("pll pulses", e, (c >= e - 2 && c <= e + 2) ? e : c);
      end
      test_done();
   end
endmodule // ccms_top_tb_top
